/* logic/tom_pkg.sv */
// package: constants, register map and carriers of the thermal model
// Notes on behaviour
// (R1) phase rise moves toward steady rise by alpha
// (R2) steady rise is (I/Imax)^2 times max rise
// (R3) model is hottest phase plus ambient
// (R4) start at steady rise or at ambient
// (R5) flags may assert on first evaluation
// (R6) pickup when steady rise plus ambient exceeds trip
// (R7) alarm while model above alarm threshold
// (R8) trip above trip threshold, inhibit set too
// (R9) inhibit holds until model below reclose threshold
// (R10) max rise relative, thresholds absolute
// (R11) sensor mode takes ambient from sensor input
// (R12) manual mode uses configured ambient value
// (R13) block forces all flags inactive
// (R14) model keeps running while blocked
// (R15) operation off disables, default off
// (R16) missing current channel gives health alarm
// (R17) thresholds below manual ambient give health alarm
// (R18) sensor on but invalid gives health alarm
// (R19) time constant seconds, 1 to 60000, 600
// (R20) max rise whole degrees, default 60
// (R21) max current amperes, default 9999999.9
// (R22) ratio is model over max rise
// (R23) each phase temperature published separately
// (R24) evaluation per tick with derived decay factor
// (R25) signed fixed point temperatures, saturating
package tom_pkg;
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned TICK_MS     = 100;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned MS_PER_S    = 1000;
    localparam int          FRAC        = 6;
    localparam int          CUR_Q       = 12;
    localparam int          SS_SHIFT    = 2 * CUR_Q - FRAC;
    localparam int          RATIO_SH    = 8;
    localparam int          ADDR_W      = 8;
    localparam logic [5:0]  DIV_STEPS   = 6'd48;
    localparam logic [47:0] ALPHA_NUM   = 48'(TICK_MS) << 16;

    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_TAU    = 8'h04;
    localparam logic [7:0] REG_IMAX   = 8'h08;
    localparam logic [7:0] REG_RISE   = 8'h0c;
    localparam logic [7:0] REG_AMB    = 8'h10;
    localparam logic [7:0] REG_ALARM  = 8'h14;
    localparam logic [7:0] REG_TRIP   = 8'h18;
    localparam logic [7:0] REG_RECL   = 8'h1c;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_PHASE_A_TEMPERATURE  = 8'h24;
    localparam logic [7:0] REG_PHASE_B_TEMPERATURE  = 8'h28;
    localparam logic [7:0] REG_PHASE_C_TEMPERATURE  = 8'h2c;
    localparam logic [7:0] REG_MODEL  = 8'h30;
    localparam logic [7:0] REG_RATIO  = 8'h34;

    localparam int CTRL_OP     = 0;
    localparam int CTRL_INIT   = 1;
    localparam int CTRL_SENS   = 2;
    localparam int STAT_PICK   = 0;
    localparam int STAT_ALARM  = 1;
    localparam int STAT_TRIP   = 2;
    localparam int STAT_INH    = 3;
    localparam int STAT_HEALTH = 4;

    localparam logic [15:0] TAU_RST   = 16'd600;
    localparam logic [15:0] TAU_MIN   = 16'd1;
    localparam logic [15:0] TAU_MAX   = 16'd60000;
    localparam logic [31:0] IMAX_RST  = 32'd99999999;
    localparam logic [7:0]  RISE_RST  = 8'd60;
    localparam logic [7:0]  ALARM_RST = 8'd50;
    localparam logic [7:0]  TRIP_RST  = 8'd60;
    localparam logic [7:0]  RECL_RST  = 8'd40;
    localparam logic signed [15:0] TEMP_HI = 16'sd16000;
    localparam logic signed [15:0] TEMP_LO = -16'sd3200;
    localparam logic [1:0]  HEALTH_OK    = 2'h0;
    localparam logic [1:0]  HEALTH_ALARM = 2'h2;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef logic signed [15:0] tom_temp_t;
    typedef logic [2:0][31:0]   tom_curr_t;
    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_ALPHA, SEQ_PHASE, SEQ_UPDATE, SEQ_RATIO, SEQ_FLAGS
    } tom_seq_e;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } tom_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tom_axi_rsp_s;

    typedef struct packed {
        logic pickup;
        logic alarm;
        logic trip;
        logic reclose_inhibit;
    } tom_flags_s;

    typedef struct packed {
        tom_temp_t   phase_a_temperature;
        tom_temp_t   phase_b_temperature;
        tom_temp_t   phase_c_temperature;
        tom_temp_t   model_temperature;
        logic [15:0] temperature_ratio;
    } tom_meas_s;
endpackage : tom_pkg

/* logic/tom_thermal_overload.sv */
// thermal overload model with its axi4-lite register slave
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
module tom_thermal_overload #(
    parameter int unsigned TICK_CYCLES_P = tom_pkg::TICK_CYCLES
) (
    input  wire logic             core_clk_in,
    input  wire logic             arst_n_in,
    input  tom_pkg::tom_axi_req_s axi_req_in,
    output tom_pkg::tom_axi_rsp_s axi_rsp_out,
    input  tom_pkg::tom_curr_t    phase_current_in,
    input  wire logic             current_channel_ok_in,
    input  tom_pkg::tom_temp_t    ambient_sensor_input_in,
    input  wire logic             ambient_sensor_valid_in,
    input  wire logic             block_in,
    output tom_pkg::tom_flags_s   flags_out,
    output tom_pkg::tom_meas_s    meas_out,
    output logic [1:0]            health_out
);
    import tom_pkg::*;

    typedef struct packed {
        tom_axi_rsp_s      rsp;
        logic [ADDR_W-1:0] waddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              op;
        logic              init_opt;
        logic              sens_en;
        logic [15:0]       tau;
        logic [31:0]       imax;
        logic [7:0]        max_rise;
        tom_temp_t         amb;
        logic [7:0]        alarm_th;
        logic [7:0]        trip_th;
        logic [7:0]        recl_th;
        logic [2:0]        blk_s;
        logic              blk;
        logic [31:0]       tick_cnt;
        tom_seq_e          seq;
        logic [1:0]        ph;
        logic [15:0]       alpha;
        logic [47:0]       div_num;
        logic [31:0]       div_den;
        logic [31:0]       div_rem;
        logic [47:0]       div_quo;
        logic [5:0]        div_cnt;
        tom_temp_t [2:0]   ss;
        tom_temp_t [2:0]   rise;
        logic              started;
        logic              pick_i;
        logic              alarm_i;
        logic              trip_i;
        logic              inhibit_i;
        tom_flags_s        flags;
        tom_meas_s         meas;
        logic [1:0]        health;
    } tom_state_s;

    tom_state_s q;
    tom_state_s d;
    logic       run_w;

    function automatic tom_temp_t tsat(input logic signed [33:0] x);
        tom_temp_t r;
        if (x > 34'(TEMP_HI)) begin
            r = TEMP_HI;
        end else if (x < 34'(TEMP_LO)) begin
            r = TEMP_LO;
        end else begin
            r = tom_temp_t'(x[15:0]);
        end
        return r;
    endfunction : tsat

    // whole-degree threshold to the fixed-point temperature scale
    function automatic tom_temp_t thr(input logic [7:0] th);
        return tom_temp_t'(16'(th) << FRAC);
    endfunction : thr

    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : wmerge

    // bit 32 flags a mapped address, bits 31:0 hold the word
    function automatic logic [32:0] regval(input tom_state_s s,
                                           input logic [7:0] a);
        logic [32:0] v;
        v = 33'h0;
        v[32] = 1'b1;
        unique case (a)
            REG_CTRL: begin
                v[CTRL_OP]   = s.op;
                v[CTRL_INIT] = s.init_opt;
                v[CTRL_SENS] = s.sens_en;
            end
            REG_TAU:   v[15:0] = s.tau;
            REG_IMAX:  v[31:0] = s.imax;
            REG_RISE:  v[7:0]  = s.max_rise;
            REG_AMB:   v[15:0] = s.amb;
            REG_ALARM: v[7:0]  = s.alarm_th;
            REG_TRIP:  v[7:0]  = s.trip_th;
            REG_RECL:  v[7:0]  = s.recl_th;
            REG_STATUS: begin
                v[STAT_PICK]  = s.flags.pickup;
                v[STAT_ALARM] = s.flags.alarm;
                v[STAT_TRIP]  = s.flags.trip;
                v[STAT_INH]   = s.flags.reclose_inhibit;
                v[STAT_HEALTH +: 2] = s.health;
            end
            REG_PHASE_A_TEMPERATURE: v[15:0] = s.meas.phase_a_temperature;
            REG_PHASE_B_TEMPERATURE: v[15:0] = s.meas.phase_b_temperature;
            REG_PHASE_C_TEMPERATURE: v[15:0] = s.meas.phase_c_temperature;
            REG_MODEL: v[15:0] = s.meas.model_temperature;
            REG_RATIO: v[15:0] = s.meas.temperature_ratio;
            default:   v = 33'h0;
        endcase
        return v;
    endfunction : regval

    assign run_w = q.op && (q.health == HEALTH_OK); // R15

    always_comb begin
        logic [31:0]        w;
        logic [32:0]        rv;
        logic [32:0]        rem_sh;
        logic [15:0]        quo;
        logic [39:0]        p40;
        tom_temp_t          env;
        tom_temp_t          ssv;
        tom_temp_t          mx;
        tom_temp_t [2:0]    pt;
        logic signed [33:0] diff;
        logic signed [33:0] step;
        logic               tick;
        logic               bad;
        logic               pk;
        w      = 32'h0;
        rv     = 33'h0;
        rem_sh = 33'h0;
        quo    = 16'h0;
        p40    = 40'h0;
        ssv    = '0;
        mx     = '0;
        pt     = '0;
        diff   = '0;
        step   = '0;
        pk     = 1'b0;
        env    = '0;
        tick   = 1'b0;
        bad    = 1'b0;
        d      = q;

        // block pin: three stages, accepted once the last two agree
        d.blk_s = {q.blk_s[1:0], block_in};
        if (q.blk_s[1] == q.blk_s[2]) begin
            d.blk = q.blk_s[2];
        end

        // axi4-lite writes: address and data taken in either order
        if (axi_req_in.awvalid && q.rsp.awready) begin
            d.rsp.awready = 1'b0;
            d.waddr       = axi_req_in.awaddr;
        end
        if (axi_req_in.wvalid && q.rsp.wready) begin
            d.rsp.wready = 1'b0;
            d.wdata      = axi_req_in.wdata;
            d.wstrb      = axi_req_in.wstrb;
        end
        if (!q.rsp.awready && !q.rsp.wready && !q.rsp.bvalid) begin
            rv = regval(q, q.waddr);
            w  = wmerge(rv[31:0], q.wdata, q.wstrb);
            d.rsp.bvalid = 1'b1;
            d.rsp.bresp  = RESP_OKAY;
            unique case (q.waddr)
                REG_CTRL: begin
                    d.op       = w[CTRL_OP];
                    d.init_opt = w[CTRL_INIT];
                    d.sens_en  = w[CTRL_SENS];
                end
                REG_TAU: begin
                    // out-of-range time constants are clamped, not refused
                    // the upper half counts too, or 70000 would wrap
                    if (w[31:16] != 16'h0 || w[15:0] > TAU_MAX) begin
                        d.tau = TAU_MAX; // R19
                    end else if (w[15:0] < TAU_MIN) begin
                        d.tau = TAU_MIN; // R19
                    end else begin
                        d.tau = w[15:0];
                    end
                end
                REG_IMAX:  d.imax     = w;
                REG_RISE:  d.max_rise = w[7:0];
                REG_AMB:   d.amb      = w[15:0];
                REG_ALARM: d.alarm_th = w[7:0];
                REG_TRIP:  d.trip_th  = w[7:0];
                REG_RECL:  d.recl_th  = w[7:0];
                default:   d.rsp.bresp = RESP_SLVERR;
            endcase
        end
        if (q.rsp.bvalid && axi_req_in.bready) begin
            d.rsp.bvalid  = 1'b0;
            d.rsp.awready = 1'b1;
            d.rsp.wready  = 1'b1;
        end

        if (axi_req_in.arvalid && q.rsp.arready) begin
            rv            = regval(q, axi_req_in.araddr);
            d.rsp.arready = 1'b0;
            d.rsp.rvalid  = 1'b1;
            d.rsp.rdata   = rv[31:0];
            d.rsp.rresp   = rv[32] ? RESP_OKAY : RESP_SLVERR;
        end
        if (q.rsp.rvalid && axi_req_in.rready) begin
            d.rsp.rvalid  = 1'b0;
            d.rsp.arready = 1'b1;
        end

        // health is judged every cycle, independent of the tick
        bad = !current_channel_ok_in; // R16
        if (!q.sens_en && $signed({8'h00, q.alarm_th}) < q.amb
            && $signed({8'h00, q.trip_th}) < q.amb
            && $signed({8'h00, q.recl_th}) < q.amb) begin
            bad = 1'b1; // R17
        end
        if (q.sens_en && !ambient_sensor_valid_in) begin
            bad = 1'b1; // R18
        end
        d.health = bad ? HEALTH_ALARM : HEALTH_OK; // R16 R17 R18

        // ambient source; thresholds stay absolute, rise stays relative
        env = q.sens_en ? ambient_sensor_input_in // R11
                        : tom_temp_t'(q.amb <<< FRAC); // R12 R10

        tick = 1'b0;
        if (q.tick_cnt == 32'(TICK_CYCLES_P - 1)) begin
            d.tick_cnt = 32'h0;
            tick       = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt + 32'd1;
        end

        // one shared serial divider; a zero divisor saturates
        if (q.div_cnt != 6'd0) begin
            rem_sh    = {q.div_rem, q.div_num[47]};
            d.div_num = {q.div_num[46:0], 1'b0};
            if (rem_sh >= {1'b0, q.div_den}) begin
                d.div_rem = 32'(rem_sh - {1'b0, q.div_den});
                d.div_quo = {q.div_quo[46:0], 1'b1};
            end else begin
                d.div_rem = rem_sh[31:0];
                d.div_quo = {q.div_quo[46:0], 1'b0};
            end
            d.div_cnt = q.div_cnt - 6'd1;
        end
        quo = (|q.div_quo[47:16]) ? 16'hffff : q.div_quo[15:0];

        // the model keeps running regardless of the block input
        unique case (q.seq) // R14
            SEQ_IDLE: begin
                if (tick && run_w) begin
                    // decay factor: tick over time constant, q0.16
                    d.div_num = ALPHA_NUM; // R24
                    d.div_den = 32'(q.tau) * 32'(MS_PER_S); // R24
                    d.div_rem = 32'h0;
                    d.div_quo = 48'h0;
                    d.div_cnt = DIV_STEPS;
                    d.seq     = SEQ_ALPHA;
                end
            end
            SEQ_ALPHA: begin
                if (q.div_cnt == 6'd0) begin
                    d.alpha   = quo;
                    d.ph      = 2'd0;
                    d.div_num = 48'(phase_current_in[0]) << CUR_Q; // R2
                    d.div_den = q.imax; // R2
                    d.div_rem = 32'h0;
                    d.div_quo = 48'h0;
                    d.div_cnt = DIV_STEPS;
                    d.seq     = SEQ_PHASE;
                end
            end
            SEQ_PHASE: begin
                if (q.div_cnt == 6'd0) begin
                    // squared current ratio scaled by the max rise
                    p40 = 40'(32'(quo) * 32'(quo)) * 40'(q.max_rise); // R2
                    p40 = p40 >> SS_SHIFT;
                    ssv = (p40 > 40'(TEMP_HI)) ? TEMP_HI
                                               : tom_temp_t'(p40[15:0]);
                    d.ss[q.ph] = ssv; // R2 R25
                    if (q.ph == 2'd2) begin
                        d.seq = SEQ_UPDATE;
                    end else begin
                        d.ph      = q.ph + 2'd1;
                        d.div_num = 48'(phase_current_in[q.ph + 2'd1])
                                    << CUR_Q;
                        d.div_rem = 32'h0;
                        d.div_quo = 48'h0;
                        d.div_cnt = DIV_STEPS;
                    end
                end
            end
            SEQ_UPDATE: begin
                for (int i = 0; i < 3; i++) begin
                    if (!q.started) begin
                        // no history yet: steady rise or zero rise
                        d.rise[i] = q.init_opt ? q.ss[i] : '0; // R4
                    end else begin
                        diff = 34'(q.ss[i]) - 34'(q.rise[i]);
                        step = (diff * $signed({18'h0, q.alpha})) >>> 16;
                        d.rise[i] = tsat(34'(q.rise[i]) + step); // R1 R25
                    end
                end
                d.started = 1'b1;
                mx = d.rise[0];
                for (int i = 0; i < 3; i++) begin
                    if (d.rise[i] > mx) begin
                        mx = d.rise[i]; // R3
                    end
                    pt[i] = tsat(34'(d.rise[i]) + 34'(env)); // R23
                end
                d.meas.phase_a_temperature = pt[0]; // R23
                d.meas.phase_b_temperature = pt[1]; // R23
                d.meas.phase_c_temperature = pt[2]; // R23
                d.meas.model_temperature = tsat(34'(mx) + 34'(env)); // R3
                // ratio q8.8; a negative model temperature reads as zero
                if (d.meas.model_temperature[15]) begin
                    d.div_num = 48'h0;
                end else begin
                    d.div_num = 48'(d.meas.model_temperature)
                                << RATIO_SH; // R22
                end
                d.div_den = 32'(q.max_rise) << FRAC; // R22
                d.div_rem = 32'h0;
                d.div_quo = 48'h0;
                d.div_cnt = DIV_STEPS;
                d.seq     = SEQ_RATIO;
            end
            SEQ_RATIO: begin
                if (q.div_cnt == 6'd0) begin
                    d.meas.temperature_ratio = quo; // R22
                    d.seq = SEQ_FLAGS;
                end
            end
            SEQ_FLAGS: begin
                for (int i = 0; i < 3; i++) begin
                    if (tsat(34'(q.ss[i]) + 34'(env)) > thr(q.trip_th)) begin
                        pk = 1'b1; // R6
                    end
                end
                d.pick_i  = pk; // R6 R5
                d.alarm_i = q.meas.model_temperature
                            > thr(q.alarm_th); // R7 R10
                d.trip_i  = q.meas.model_temperature
                            > thr(q.trip_th); // R8 R10
                // set wins over release so a fresh trip is never lost
                if (d.trip_i) begin
                    d.inhibit_i = 1'b1; // R8
                end else if (q.meas.model_temperature
                             < thr(q.recl_th)) begin
                    d.inhibit_i = 1'b0; // R9
                end
                d.seq = SEQ_IDLE;
            end
            default: d.seq = SEQ_IDLE;
        endcase

        if (!run_w) begin
            d.seq       = SEQ_IDLE; // R15
            d.div_cnt   = 6'd0;
            d.started   = 1'b0; // R4
            d.pick_i    = 1'b0;
            d.alarm_i   = 1'b0;
            d.trip_i    = 1'b0;
            d.inhibit_i = 1'b0;
        end

        // block only masks the flags; internal state keeps evolving
        d.flags.pickup          = q.pick_i && run_w && !q.blk; // R13
        d.flags.alarm           = q.alarm_i && run_w && !q.blk; // R13
        d.flags.trip            = q.trip_i && run_w && !q.blk; // R13
        d.flags.reclose_inhibit = q.inhibit_i && run_w && !q.blk; // R13
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            q             <= '0;
            q.seq         <= SEQ_IDLE;
            q.rsp.awready <= 1'b1;
            q.rsp.wready  <= 1'b1;
            q.rsp.arready <= 1'b1;
            q.tau         <= TAU_RST; // R19
            q.imax        <= IMAX_RST; // R21
            q.max_rise    <= RISE_RST; // R20
            q.alarm_th    <= ALARM_RST;
            q.trip_th     <= TRIP_RST;
            q.recl_th     <= RECL_RST;
        end else begin
            q <= d;
        end
    end

    assign axi_rsp_out = q.rsp;
    assign flags_out   = q.flags;
    assign meas_out    = q.meas;
    assign health_out  = q.health;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);

    a_block_forces_off: // R13
    assert property (q.blk |=> flags_out == '0)
        else $error("flag active while blocked");

    a_trip_sets_inhibit: // R8
    assert property (flags_out.trip |-> flags_out.reclose_inhibit)
        else $error("trip without reclose inhibit");

    a_alarm_above_thr: // R7
    assert property ($rose(q.alarm_i) |->
        $past(q.meas.model_temperature > thr(q.alarm_th)))
        else $error("alarm set below alarm threshold");

    a_trip_above_thr: // R8
    assert property ($rose(q.trip_i) |->
        $past(q.meas.model_temperature > thr(q.trip_th)))
        else $error("trip set below trip threshold");

    a_inhibit_release: // R9
    assert property ($fell(q.inhibit_i) |->
        $past(!run_w || q.meas.model_temperature < thr(q.recl_th)))
        else $error("inhibit released above reclose threshold");

    a_op_off_quiet: // R15
    assert property (!q.op |=> ##1 flags_out == '0)
        else $error("flags active with operation off");

    a_sensor_health: // R18
    assert property (q.sens_en && !ambient_sensor_valid_in
        |=> health_out == HEALTH_ALARM)
        else $error("invalid sensor not flagged in health");

    a_channel_health: // R16
    assert property (!current_channel_ok_in
        |=> health_out == HEALTH_ALARM ##1 flags_out == '0)
        else $error("missing current channel not flagged");

    a_eval_bounded: // R24
    assert property ($past(q.seq) == SEQ_IDLE && q.seq == SEQ_ALPHA
        |-> ##[1:300] (q.seq == SEQ_FLAGS || !run_w))
        else $error("evaluation did not finish in time");
endmodule : tom_thermal_overload

/* sim/tom_meas_partner.sv */
// partner: phase current channel feeding the thermal model
module tom_meas_partner (
    input  wire logic          core_clk_in,
    input  wire logic [31:0]   amps_in,
    output tom_pkg::tom_curr_t phase_current_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import tom_pkg::*;
    // a and c carry half, so only b decides the hottest phase
    always_ff @(posedge core_clk_in) begin
        phase_current_out <= {amps_in >> 1, amps_in, amps_in >> 1};
    end
endmodule : tom_meas_partner

/* sim/tb_thermal_overload_model.sv */
// bench: registers, evaluation, block and health of the thermal model
module tb_thermal_overload_model;
    timeunit 1ns;
    timeprecision 1ns;
    import tom_pkg::*;
    logic         clk, rst_n, blk, ok, sv, fix;
    logic [31:0]  amps;
    logic [33:0]  e;
    tom_axi_req_s rq;
    tom_axi_rsp_s rs, snap;
    tom_flags_s   fl;
    tom_meas_s    ms;
    logic [1:0]   hl;
    tom_curr_t    cur;
    tom_temp_t    amb;
    logic [33:0]  exp_q[$];
    int           err_total, n_checks, seed;

    tom_meas_partner i_part (.core_clk_in(clk), .amps_in(amps),
        .phase_current_out(cur));
    tom_thermal_overload #(.TICK_CYCLES_P(400)) i_dut (
        .core_clk_in(clk), .arst_n_in(rst_n), .axi_req_in(rq),
        .axi_rsp_out(rs), .phase_current_in(cur),
        .current_channel_ok_in(ok), .ambient_sensor_input_in(amb),
        .ambient_sensor_valid_in(sv), .block_in(blk),
        .flags_out(fl), .meas_out(ms), .health_out(hl));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ready sampled mid-cycle so the next rising edge is the handshake
    task automatic step;
        @(negedge clk);
        snap = rs;
        @(posedge clk);
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        rq.awaddr <= a;
        rq.wdata <= d;
        rq.wstrb <= 4'hf;
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        rq.bready <= 1'b1;
        while (!(ad && wd)) begin
            step();
            if (snap.awready) ad = 1'b1;
            if (snap.wready) wd = 1'b1;
            if (ad) rq.awvalid <= 1'b0;
            if (wd) rq.wvalid <= 1'b0;
        end
        do step(); while (!snap.bvalid);
        rq.bready <= 1'b0;
        @(posedge clk);
    endtask : wr

    // expected value carries the response code above the data word
    task automatic rd(input logic [7:0] a, input logic [33:0] x);
        exp_q.push_back(x);
        rq.araddr <= a;
        rq.arvalid <= 1'b1;
        rq.rready <= 1'b1;
        do step(); while (!snap.arready);
        rq.arvalid <= 1'b0;
        do step(); while (!snap.rvalid);
        rq.rready <= 1'b0;
        @(posedge clk);
    endtask : rd

    always @(negedge clk) begin
        if (rs.rvalid === 1'b1 && rq.rready) begin
            e = exp_q.pop_front();
            n_checks++;
            if ({rs.rresp, rs.rdata} !== e) begin
                err_total++;
                $display("[FAIL] %0t got %h exp %h", $time,
                         {rs.rresp, rs.rdata}, e);
            end
        end
    end

    // noise must never show in manual mode; later a fixed 5 degc reading
    always @(posedge clk) amb <= fix ? 16'h0140 : tom_temp_t'($random(seed));

    task automatic tally_and_finish;
        if (err_total == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (9000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        {rst_n, blk, amps, rq} = '0;
        {ok, sv, fix} = 3'b110;
        seed = 95156;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(REG_CTRL, 32'h0);
        rd(REG_TAU, 32'h258);
        rd(REG_IMAX, 32'h05f5e0ff);
        rd(REG_RISE, 32'h3c);
        rd(REG_TRIP, 32'h3c);
        rd(8'hfc, 34'h200000000);
        wr(REG_TAU, 32'h11170);
        rd(REG_TAU, 32'hea60);
        wr(REG_IMAX, 32'h64);
        amps <= 32'hc8;
        wr(REG_CTRL, 32'h3);
        for (int i = 0; i < 3000 && fl.trip !== 1'b1; i++) step();
        rd(REG_STATUS, 32'h0f);
        rd(REG_PHASE_A_TEMPERATURE, 32'h0f00);
        rd(REG_PHASE_B_TEMPERATURE, 32'h3c00);
        rd(REG_MODEL, 32'h3c00);
        rd(REG_RATIO, 32'h0400);
        blk <= 1'b1;
        repeat (8) step();
        rd(REG_STATUS, 32'h0);
        rd(REG_MODEL, 32'h3c00);
        blk <= 1'b0;
        ok <= 1'b0;
        repeat (3) step();
        rd(REG_STATUS, 32'h20);
        {ok, sv, fix} <= 3'b101;
        wr(REG_CTRL, 32'h7);
        repeat (3) step();
        rd(REG_STATUS, 32'h20);
        sv <= 1'b1;
        repeat (700) step();
        rd(REG_MODEL, 32'h3d40);
        wr(REG_CTRL, 32'h3);
        wr(REG_AMB, 32'h64);
        repeat (2) step();
        rd(REG_STATUS, 32'h20);
        tally_and_finish();
    end
endmodule : tb_thermal_overload_model
